// ===== dsl_lock.sv
// Drive security lock state machine with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "dsl_cfg.svh"

module dsl_lock #(
  parameter int PW_W = `DSL_PW_W,
  parameter logic [`DSL_PW_W-1:0] MASTER_DEFAULT = `DSL_MASTER_DEFAULT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DSL_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host security command port
  input wire logic hard_rst,
  input wire logic cmd_valid,
  input wire dsl_pkg::dsl_cmd_s cmd,
  output logic cmd_done,
  output logic cmd_abort,
  // Drive side
  output logic media_en,
  output logic erase_start,
  output logic irq
);

  dsl_pkg::dsl_mode_e mode_q, mode_d;
  logic lock_en_q, lock_en_d;
  logic max_lvl_q, max_lvl_d;
  logic [PW_W-1:0] user_pw_q, user_pw_d;
  logic [PW_W-1:0] master_pw_q, master_pw_d;
  logic [`DSL_REV_W-1:0] rev_q, rev_d;
  logic [`DSL_TRY_W-1:0] try_q, try_d;
  logic limit_q, limit_d;
  logic done_q, done_d;
  logic abort_q, abort_d;
  logic erase_q, erase_d;
  logic ev_unlock, ev_limit;
  logic pw_hit;
  logic pw_good;
  logic [`DSL_IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [`DSL_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] sec_word;
  logic addr_ok;
  logic wr_acc;

  dsl_pw_match #(
    .PW_W(PW_W)
  ) u_match (
    .user_pw(user_pw_q),
    .master_pw(master_pw_q),
    .user_set(lock_en_q),
    .cand_pw(cmd.pw),
    .cand_master(cmd.master),
    .hit(pw_hit)
  );

  // Master match is refused for unlocking at maximum level
  assign pw_good = pw_hit && !(cmd.master && max_lvl_q);

  // Security state machine
  always_comb begin
    mode_d = mode_q;
    lock_en_d = lock_en_q;
    max_lvl_d = max_lvl_q;
    user_pw_d = user_pw_q;
    master_pw_d = master_pw_q;
    rev_d = rev_q;
    try_d = try_q;
    limit_d = limit_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    erase_d = 1'b0;
    ev_unlock = 1'b0;
    if (hard_rst) begin
      try_d = `DSL_TRY_ZERO;
      limit_d = 1'b0;
      // Frozen survives a hard reset; only power removal ends it
      if (mode_q != dsl_pkg::DSL_FROZEN) begin
        mode_d = lock_en_q ? dsl_pkg::DSL_LOCKED : dsl_pkg::DSL_UNLOCKED;
      end
    end else if (cmd_valid) begin
      done_d = 1'b1;
      case (cmd.kind)
        dsl_pkg::DSL_CMD_MEDIA, dsl_pkg::DSL_CMD_QUEUED, dsl_pkg::DSL_CMD_SERVICE: begin
          abort_d = (mode_q == dsl_pkg::DSL_LOCKED);
        end
        dsl_pkg::DSL_CMD_SET_PW: begin
          if (mode_q != dsl_pkg::DSL_UNLOCKED) begin
            abort_d = 1'b1;
          end else if (cmd.master) begin
            master_pw_d = cmd.pw;
            if (cmd.rev >= `DSL_REV_MIN && cmd.rev <= `DSL_REV_MAX) begin
              rev_d = cmd.rev;
            end
          end else begin
            user_pw_d = cmd.pw;
            max_lvl_d = cmd.max_level;
            lock_en_d = 1'b1;
          end
        end
        dsl_pkg::DSL_CMD_DISABLE_PW: begin
          if (mode_q != dsl_pkg::DSL_UNLOCKED || !pw_good) begin
            abort_d = 1'b1;
          end else begin
            lock_en_d = 1'b0;
          end
        end
        dsl_pkg::DSL_CMD_UNLOCK, dsl_pkg::DSL_CMD_ERASE_UNIT: begin
          if (mode_q == dsl_pkg::DSL_FROZEN || limit_q) begin
            abort_d = 1'b1;
          end else if (cmd.kind == dsl_pkg::DSL_CMD_UNLOCK ? pw_good : pw_hit) begin
            // Erase takes the master at either level
            mode_d = dsl_pkg::DSL_UNLOCKED;
            ev_unlock = (mode_q == dsl_pkg::DSL_LOCKED);
            if (cmd.kind == dsl_pkg::DSL_CMD_ERASE_UNIT) begin
              erase_d = 1'b1;
              lock_en_d = 1'b0;
              user_pw_d = `DSL_USER_DEFAULT;
            end
          end else begin
            abort_d = 1'b1;
            // A correct master at maximum level is a refusal, not a mismatch
            if (!pw_hit) begin
              try_d = try_q + `DSL_TRY_ONE;
              limit_d = (try_d == `DSL_TRY_LIMIT);
            end
          end
        end
        dsl_pkg::DSL_CMD_FREEZE: begin
          if (mode_q == dsl_pkg::DSL_LOCKED) begin
            abort_d = 1'b1;
          end else begin
            mode_d = dsl_pkg::DSL_FROZEN;
          end
        end
        default: begin
          abort_d = 1'b0;
        end
      endcase
    end
  end

  assign ev_limit = limit_d && !limit_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= dsl_pkg::DSL_UNLOCKED;
      lock_en_q <= 1'b0;
      max_lvl_q <= 1'b0;
      user_pw_q <= `DSL_USER_DEFAULT;
      master_pw_q <= MASTER_DEFAULT;
      rev_q <= `DSL_REV_FACTORY;
      try_q <= `DSL_TRY_ZERO;
      limit_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      lock_en_q <= lock_en_d;
      max_lvl_q <= max_lvl_d;
      user_pw_q <= user_pw_d;
      master_pw_q <= master_pw_d;
      rev_q <= rev_d;
      try_q <= try_d;
      limit_q <= limit_d;
      done_q <= done_d;
      abort_q <= abort_d;
      erase_q <= erase_d;
    end
  end

  assign cmd_done = done_q;
  assign cmd_abort = abort_q;
  assign erase_start = erase_q;
  assign media_en = (mode_q != dsl_pkg::DSL_LOCKED);

  // Security word as seen in identify data, plus the mismatch count
  always_comb begin
    sec_word = 32'h0000_0000;
    sec_word[`DSL_SEC_SUPPORTED] = 1'b1;
    sec_word[`DSL_SEC_ENABLED] = lock_en_q;
    sec_word[`DSL_SEC_LOCKED] = (mode_q == dsl_pkg::DSL_LOCKED);
    sec_word[`DSL_SEC_FROZEN] = (mode_q == dsl_pkg::DSL_FROZEN);
    sec_word[`DSL_SEC_LIMIT] = limit_q;
    sec_word[`DSL_SEC_MAXLVL] = max_lvl_q;
    sec_word[`DSL_SEC_CNT_LO +: `DSL_TRY_W] = try_q;
  end

  // APB slave, zero wait states; read data is captured in the setup cycle
  assign addr_ok = (paddr == `DSL_OFF_SEC) || (paddr == `DSL_OFF_REV) ||
                   (paddr == `DSL_OFF_IRQ_STAT) || (paddr == `DSL_OFF_IRQ_MASK);
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    rdata_d = rdata_q;
    irq_mask_d = irq_mask_q;
    // Hardware set wins over a same-cycle write-one clear
    irq_stat_d = irq_stat_q;
    if (wr_acc && paddr == `DSL_OFF_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~pwdata[`DSL_IRQ_W-1:0];
    end
    irq_stat_d[`DSL_IRQ_ABORT] = irq_stat_d[`DSL_IRQ_ABORT] | abort_d;
    irq_stat_d[`DSL_IRQ_UNLOCK] = irq_stat_d[`DSL_IRQ_UNLOCK] | ev_unlock;
    irq_stat_d[`DSL_IRQ_LIMIT] = irq_stat_d[`DSL_IRQ_LIMIT] | ev_limit;
    if (wr_acc && paddr == `DSL_OFF_IRQ_MASK) begin
      irq_mask_d = pwdata[`DSL_IRQ_W-1:0];
    end
    if (psel && !penable) begin
      case (paddr)
        `DSL_OFF_SEC: rdata_d = sec_word;
        `DSL_OFF_REV: rdata_d = {16'h0000, rev_q};
        `DSL_OFF_IRQ_STAT: rdata_d = {29'h0000_0000, irq_stat_q};
        `DSL_OFF_IRQ_MASK: rdata_d = {29'h0000_0000, irq_mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      irq_stat_q <= `DSL_IRQ_NONE;
      irq_mask_q <= `DSL_IRQ_NONE;
    end else begin
      rdata_q <= rdata_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign prdata = rdata_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unlock_req;
    cmd_valid && !hard_rst && cmd.kind == dsl_pkg::DSL_CMD_UNLOCK;
  endsequence

  property p_frozen_sticky;
    mode_q == dsl_pkg::DSL_FROZEN |=> mode_q == dsl_pkg::DSL_FROZEN;
  endproperty
  a_frozen_sticky: assert property (p_frozen_sticky)
    else $error("frozen mode was left");

  property p_locked_media;
    cmd_valid && !hard_rst && mode_q == dsl_pkg::DSL_LOCKED &&
      cmd.kind == dsl_pkg::DSL_CMD_MEDIA |=> cmd_done && cmd_abort && !media_en;
  endproperty
  a_locked_media: assert property (p_locked_media)
    else $error("media command ran while locked");

  property p_frozen_pw;
    cmd_valid && !hard_rst && mode_q == dsl_pkg::DSL_FROZEN &&
      (cmd.kind == dsl_pkg::DSL_CMD_SET_PW || cmd.kind == dsl_pkg::DSL_CMD_ERASE_UNIT)
      |=> cmd_abort && $stable(lock_en_q) && !erase_start;
  endproperty
  a_frozen_pw: assert property (p_frozen_pw)
    else $error("password command ran while frozen");

  property p_unlock_ok;
    s_unlock_req ##0 (mode_q == dsl_pkg::DSL_LOCKED && !limit_q && pw_good)
      |=> mode_q == dsl_pkg::DSL_UNLOCKED && !cmd_abort ##1 irq_stat_q[`DSL_IRQ_UNLOCK];
  endproperty
  a_unlock_ok: assert property (p_unlock_ok)
    else $error("good unlock did not unlock");

  property p_max_master;
    s_unlock_req ##0 (mode_q == dsl_pkg::DSL_LOCKED && max_lvl_q && cmd.master)
      |=> mode_q == dsl_pkg::DSL_LOCKED && cmd_abort;
  endproperty
  a_max_master: assert property (p_max_master)
    else $error("master unlocked at maximum level");

  property p_mismatch_count;
    s_unlock_req ##0 (mode_q != dsl_pkg::DSL_FROZEN && !limit_q && !pw_hit)
      |=> try_q == $past(try_q) + `DSL_TRY_ONE && cmd_abort;
  endproperty
  a_mismatch_count: assert property (p_mismatch_count)
    else $error("mismatch not counted");

  property p_limit_flag;
    try_q == `DSL_TRY_LIMIT |-> limit_q && sec_word[`DSL_SEC_LIMIT];
  endproperty
  a_limit_flag: assert property (p_limit_flag)
    else $error("limit reached without flag");

  property p_limit_abort;
    s_unlock_req ##0 limit_q |=> cmd_abort && mode_q == $past(mode_q);
  endproperty
  a_limit_abort: assert property (p_limit_abort)
    else $error("unlock ran past attempt limit");

  property p_hard_clear;
    hard_rst |=> try_q == `DSL_TRY_ZERO && !limit_q;
  endproperty
  a_hard_clear: assert property (p_hard_clear)
    else $error("hard reset left counter or flag");

  property p_lock_on_reset;
    hard_rst && lock_en_q && mode_q != dsl_pkg::DSL_FROZEN |=> mode_q == dsl_pkg::DSL_LOCKED;
  endproperty
  a_lock_on_reset: assert property (p_lock_on_reset)
    else $error("armed lock not applied at hard reset");

  property p_user_set;
    cmd_valid && !hard_rst && mode_q == dsl_pkg::DSL_UNLOCKED &&
      cmd.kind == dsl_pkg::DSL_CMD_SET_PW && !cmd.master
      |=> lock_en_q && mode_q == dsl_pkg::DSL_UNLOCKED;
  endproperty
  a_user_set: assert property (p_user_set)
    else $error("user password did not arm the lock");

  property p_master_nolock;
    cmd_valid && !hard_rst && cmd.kind == dsl_pkg::DSL_CMD_SET_PW && cmd.master
      |=> lock_en_q == $past(lock_en_q);
  endproperty
  a_master_nolock: assert property (p_master_nolock)
    else $error("master password changed the lock");

  property p_rev_range;
    rev_q >= `DSL_REV_MIN && rev_q <= `DSL_REV_MAX;
  endproperty
  a_rev_range: assert property (p_rev_range)
    else $error("revision code out of range");

endmodule // dsl_lock

`default_nettype wire

// ===== dsl_cfg.svh
// Constants for the drive security lock block
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH

// Password and identify-data widths
`define DSL_PW_W 32
`define DSL_REV_W 16
`define DSL_TRY_W 3

// Attempt limit and revision code range
`define DSL_TRY_LIMIT 3'h5
`define DSL_TRY_ZERO 3'h0
`define DSL_TRY_ONE 3'h1
`define DSL_REV_FACTORY 16'hFFFE
`define DSL_REV_MIN 16'h0001
`define DSL_REV_MAX 16'hFFFE
`define DSL_MASTER_DEFAULT 32'h0000_0000
`define DSL_USER_DEFAULT 32'h0000_0000

// APB register byte offsets
`define DSL_ADDR_W 12
`define DSL_OFF_SEC 12'h000
`define DSL_OFF_REV 12'h004
`define DSL_OFF_IRQ_STAT 12'h008
`define DSL_OFF_IRQ_MASK 12'h00C

// Security word fields
`define DSL_SEC_SUPPORTED 0
`define DSL_SEC_ENABLED 1
`define DSL_SEC_LOCKED 2
`define DSL_SEC_FROZEN 3
`define DSL_SEC_LIMIT 4
`define DSL_SEC_MAXLVL 5
`define DSL_SEC_CNT_LO 8

// Interrupt status bits
`define DSL_IRQ_W 3
`define DSL_IRQ_ABORT 0
`define DSL_IRQ_UNLOCK 1
`define DSL_IRQ_LIMIT 2
`define DSL_IRQ_NONE 3'h0

`endif

// ===== dsl_pkg.sv
// Types shared by the drive security lock block
`include "dsl_cfg.svh"

package dsl_pkg;

  typedef enum logic [1:0] {
    DSL_UNLOCKED,
    DSL_LOCKED,
    DSL_FROZEN
  } dsl_mode_e;

  typedef enum logic [3:0] {
    DSL_CMD_MEDIA,
    DSL_CMD_QUEUED,
    DSL_CMD_SERVICE,
    DSL_CMD_SET_PW,
    DSL_CMD_DISABLE_PW,
    DSL_CMD_UNLOCK,
    DSL_CMD_ERASE_PREP,
    DSL_CMD_ERASE_UNIT,
    DSL_CMD_FREEZE,
    DSL_CMD_OTHER
  } dsl_cmd_e;

  typedef struct packed {
    dsl_cmd_e kind;
    logic master;
    logic max_level;
    logic [`DSL_REV_W-1:0] rev;
    logic [`DSL_PW_W-1:0] pw;
  } dsl_cmd_s;

endpackage

// ===== dsl_pw_match.sv
// Password comparator for the drive security lock
`timescale 1ns/1ps
`default_nettype none
`include "dsl_cfg.svh"

module dsl_pw_match #(
  parameter int PW_W = `DSL_PW_W
) (
  // Stored passwords
  input wire logic [PW_W-1:0] user_pw,
  input wire logic [PW_W-1:0] master_pw,
  input wire logic user_set,
  // Presented password
  input wire logic [PW_W-1:0] cand_pw,
  input wire logic cand_master,
  // Result
  output logic hit
);

  // A user password that was never set cannot be matched
  assign hit = cand_master ? (cand_pw == master_pw) : (user_set && (cand_pw == user_pw));

endmodule // dsl_pw_match

`default_nettype wire

// ===== dsl_host_model.sv
// Host adapter model that issues security commands to the lock block
`timescale 1ns/1ps
`default_nettype none
`include "dsl_cfg.svh"

module dsl_host_model (
  // Clock
  input wire logic pclk,
  // Command port
  output logic cmd_valid,
  output dsl_pkg::dsl_cmd_s cmd,
  input wire logic cmd_done,
  input wire logic cmd_abort,
  input wire logic erase_start
);
  initial begin
    cmd_valid = 1'h0;
    cmd = '0;
  end

  // Callers set the master password before any user password
  task automatic issue(input dsl_pkg::dsl_cmd_e k, input logic m, input logic ml,
      input logic [15:0] rv, input logic [31:0] p, output logic ab, output logic er);
    int n;
    ab = 1'hx;
    er = 1'hx;
    @(posedge pclk);
    cmd_valid <= 1'h1;
    cmd <= '{kind: k, master: m, max_level: ml, rev: rv, pw: p};
    @(posedge pclk);
    cmd_valid <= 1'h0;
    // Released bus shows junk, so a stale command cannot pass unnoticed
    cmd <= dsl_pkg::dsl_cmd_s'(~cmd);
    for (n = 0; n < 4; n++) begin
      @(posedge pclk);
      if (cmd_done === 1'h1) begin
        ab = cmd_abort;
        er = erase_start;
        break;
      end
    end
  endtask
endmodule // dsl_host_model

`default_nettype wire

// ===== drive_security_lock_fsm_bench.sv
// Self-checking bench for the drive security lock block
`timescale 1ns/1ps
`default_nettype none
`include "dsl_cfg.svh"

module drive_security_lock_fsm_bench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic hard_rst = 1'h0;
  logic [`DSL_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, cmd_valid, cmd_done, cmd_abort, media_en, erase_start, irq;
  dsl_pkg::dsl_cmd_s cmd;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic ab, er, err;
  logic [31:0] rd;
  localparam logic [31:0] MPW = 32'hA5A5_5A5A;
  localparam logic [31:0] UPW = 32'h1234_5678;

  always #5 pclk = ~pclk;

  dsl_lock u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hard_rst(hard_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_done(cmd_done), .cmd_abort(cmd_abort), .media_en(media_en),
    .erase_start(erase_start), .irq(irq));

  dsl_host_model u_host (.pclk(pclk), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_done(cmd_done), .cmd_abort(cmd_abort), .erase_start(erase_start));

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, well beyond the fewer than two hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // pready is tied high, so this wait ends after one cycle
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic sec(input logic [31:0] exp);
    apb(1'h0, `DSL_OFF_SEC, 32'h0);
    chk(rd, exp);
  endtask

  task automatic hrst();
    @(posedge pclk);
    hard_rst <= 1'h1;
    @(posedge pclk);
    hard_rst <= 1'h0;
  endtask

  task automatic t_reset();
    sec(32'h1);
    apb(1'h0, `DSL_OFF_REV, 32'h0);
    chk(rd, 32'h0000_FFFE);
    chk({31'h0, media_en}, 32'h1);
    u_host.issue(dsl_pkg::DSL_CMD_MEDIA, 1'h0, 1'h0, 16'h0, 32'h0, ab, er);
    chk({31'h0, ab}, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_passwords();
    u_host.issue(dsl_pkg::DSL_CMD_SET_PW, 1'h1, 1'h0, 16'h0005, MPW, ab, er);
    sec(32'h1);
    u_host.issue(dsl_pkg::DSL_CMD_SET_PW, 1'h1, 1'h0, 16'h0000, MPW, ab, er);
    apb(1'h0, `DSL_OFF_REV, 32'h0);
    chk(rd, 32'h0000_0005);
    u_host.issue(dsl_pkg::DSL_CMD_SET_PW, 1'h0, 1'h0, 16'h0, UPW, ab, er);
    sec(32'h3);
    chk({31'h0, media_en}, 32'h1);
    hrst();
    sec(32'h7);
    chk({31'h0, media_en}, 32'h0);
  endtask

  task automatic t_locked();
    dsl_pkg::dsl_cmd_e k [6] = '{dsl_pkg::DSL_CMD_MEDIA, dsl_pkg::DSL_CMD_QUEUED,
      dsl_pkg::DSL_CMD_SERVICE, dsl_pkg::DSL_CMD_SET_PW, dsl_pkg::DSL_CMD_DISABLE_PW,
      dsl_pkg::DSL_CMD_FREEZE};
    foreach (k[i]) begin
      u_host.issue(k[i], 1'h0, 1'h0, 16'h0, UPW, ab, er);
      chk({31'h0, ab}, 32'h1);
    end
    u_host.issue(dsl_pkg::DSL_CMD_OTHER, 1'h0, 1'h0, 16'h0, 32'h0, ab, er);
    chk({31'h0, ab}, 32'h0);
    u_host.issue(dsl_pkg::DSL_CMD_ERASE_PREP, 1'h0, 1'h0, 16'h0, 32'h0, ab, er);
    chk({31'h0, ab}, 32'h0);
  endtask

  task automatic t_limit();
    int i;
    apb(1'h1, `DSL_OFF_IRQ_MASK, 32'h4);
    for (i = 0; i < 5; i++) begin
      u_host.issue(dsl_pkg::DSL_CMD_UNLOCK, i[0], 1'h0, 16'h0, 32'hDEAD_0000 + i, ab, er);
      chk({31'h0, ab}, 32'h1);
      sec(32'h7 | ((i + 1) << 8) | (i == 4 ? 32'h10 : 32'h0));
    end
    chk({31'h0, irq}, 32'h1);
    u_host.issue(dsl_pkg::DSL_CMD_UNLOCK, 1'h0, 1'h0, 16'h0, UPW, ab, er);
    chk({31'h0, ab}, 32'h1);
    sec(32'h517);
    apb(1'h1, `DSL_OFF_IRQ_STAT, 32'h7);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    hrst();
    sec(32'h7);
    u_host.issue(dsl_pkg::DSL_CMD_UNLOCK, 1'h1, 1'h0, 16'h0, MPW, ab, er);
    chk({31'h0, ab}, 32'h0);
    chk({31'h0, media_en}, 32'h1);
    sec(32'h3);
  endtask

  task automatic t_frozen();
    dsl_pkg::dsl_cmd_e k [4] = '{dsl_pkg::DSL_CMD_SET_PW, dsl_pkg::DSL_CMD_DISABLE_PW,
      dsl_pkg::DSL_CMD_UNLOCK, dsl_pkg::DSL_CMD_ERASE_UNIT};
    u_host.issue(dsl_pkg::DSL_CMD_FREEZE, 1'h0, 1'h0, 16'h0, 32'h0, ab, er);
    chk({31'h0, ab}, 32'h0);
    foreach (k[i]) begin
      u_host.issue(k[i], 1'h0, 1'h0, 16'h0, UPW, ab, er);
      chk({31'h0, ab}, 32'h1);
    end
    u_host.issue(dsl_pkg::DSL_CMD_MEDIA, 1'h0, 1'h0, 16'h0, 32'h0, ab, er);
    chk({31'h0, ab}, 32'h0);
    hrst();
    sec(32'hB);
    chk({31'h0, media_en}, 32'h1);
  endtask

  task automatic t_max();
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    sec(32'h1);
    u_host.issue(dsl_pkg::DSL_CMD_SET_PW, 1'h1, 1'h0, 16'h0001, MPW, ab, er);
    u_host.issue(dsl_pkg::DSL_CMD_SET_PW, 1'h0, 1'h1, 16'h0, UPW, ab, er);
    hrst();
    sec(32'h27);
    u_host.issue(dsl_pkg::DSL_CMD_UNLOCK, 1'h1, 1'h0, 16'h0, MPW, ab, er);
    chk({31'h0, ab}, 32'h1);
    u_host.issue(dsl_pkg::DSL_CMD_ERASE_UNIT, 1'h1, 1'h0, 16'h0, MPW, ab, er);
    chk({30'h0, ab, er}, 32'h1);
    chk({31'h0, media_en}, 32'h1);
    // Erase drops the lock but keeps the chosen level
    sec(32'h21);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_passwords();
    t_locked();
    t_limit();
    t_frozen();
    t_max();
    conclude();
  end
endmodule // drive_security_lock_fsm_bench

`default_nettype wire
